// >>> rtl/i2crd_cfg.svh
`ifndef I2CRD_CFG_SVH
`define I2CRD_CFG_SVH

// Bit positions in the synchroniser bus
`define I2CRD_SYN_W      5
`define I2CRD_SYN_SCL    4
`define I2CRD_SYN_SDA    3
`define I2CRD_SYN_ASL    2:0

// Idle bus: both lines high, select pins low
`define I2CRD_SYN_RST    5'h18

`define I2CRD_ADDR_W     7
`define I2CRD_BYTE_W     8
`define I2CRD_LAST_BIT   3'h7
`define I2CRD_PTR_RST    8'h00

`endif

// >>> rtl/i2crd_pkg.sv
package i2crd_pkg;

    typedef enum logic [7:0] {
        I2CRD_IDLE = 8'h01,
        I2CRD_ADDR = 8'h02,
        I2CRD_AACK = 8'h04,
        I2CRD_PTR  = 8'h08,
        I2CRD_NA10 = 8'h10,
        I2CRD_TX   = 8'h20,
        I2CRD_MACK = 8'h40,
        I2CRD_SKIP = 8'h80
    } i2crd_st_t;

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] flt;
    } i2crd_sync_t;

    typedef struct packed {
        i2crd_st_t  st;
        i2crd_st_t  nxt;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic       ack_on;
        logic       sda_oe;
        logic       sda_o;
        logic       rd_stb;
        logic       busy;
        logic       scl_p;
        logic       sda_p;
    } i2crd_state_t;

endpackage

// >>> rtl/i2crd_slave.sv
`timescale 1ns/100ps
`include "i2crd_cfg.svh"

module i2crd_slave
    import i2crd_pkg::*;
#(
    parameter logic [3:0] DEV_ID = 4'h5  // Arbitrary value
)
(
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic [2:0] addr_sel,
    output logic [7:0]      reg_ptr,
    input  wire logic [7:0] reg_rdata,
    output logic            rd_strobe,
    output logic            busy
);

    // Previous-sample flops start at the idle level so the first filtered sample after reset shows no edge
    localparam i2crd_state_t RST = '{
        st:     I2CRD_IDLE,
        nxt:    I2CRD_SKIP,
        cnt:    3'h0,
        sh:     8'h00,
        ptr:    `I2CRD_PTR_RST,
        ack_on: 1'b0,
        sda_oe: 1'b0,
        sda_o:  1'b0,
        rd_stb: 1'b0,
        busy:   1'b0,
        scl_p:  1'b1,
        sda_p:  1'b1
    };

    i2crd_state_t             q;
    i2crd_state_t             d;
    logic [`I2CRD_SYN_W-1:0]  syn;
    logic                     scl;
    logic                     sda;
    logic [2:0]               asel;
    logic                     scl_rise;
    logic                     scl_fall;
    logic                     start_det;
    logic                     stop_det;
    logic [`I2CRD_ADDR_W-1:0] own_addr;
    logic                     addr_hit;

    function automatic logic went_high(input logic prev, input logic now);
        went_high = ~prev & now;
    endfunction

    function automatic logic went_low(input logic prev, input logic now);
        went_low = prev & ~now;
    endfunction

    function automatic logic last_bit(input logic [2:0] cnt);
        last_bit = (cnt == `I2CRD_LAST_BIT);
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b);
        shift_in = {sh[6:0], b};
    endfunction

    // Open drain: a 0 is sent by pulling the line, a 1 by letting the pull-up win
    function automatic logic pull_for(input logic b);
        pull_for = ~b;
    endfunction

    // Three-stage filter adds about four sys_clk cycles of lag, tiny against a 1.25 us fast-mode half period
    i2crd_sync u_sync (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .din     ({scl_i, sda_i, addr_sel}),
        .dout    (syn)
    );

    assign scl      = syn[`I2CRD_SYN_SCL];
    assign sda      = syn[`I2CRD_SYN_SDA];
    assign asel     = syn[`I2CRD_SYN_ASL];
    assign own_addr = {DEV_ID, asel};
    // Select pins count as filtered at the R/W bit; a strap that moves after the R/W bit applies from the next frame
    assign addr_hit = (q.sh[6:0] == own_addr);

    assign scl_rise  = went_high(q.scl_p, scl);
    assign scl_fall  = went_low(q.scl_p, scl);
    // SDA edges while SCL stays high are framing, never data
    assign start_det = scl & q.scl_p & went_low(q.sda_p, sda);
    assign stop_det  = scl & q.scl_p & went_high(q.sda_p, sda);

    always_comb begin
        d        = q;
        d.rd_stb = 1'b0;
        d.scl_p  = scl;
        d.sda_p  = sda;
        d.sda_o  = 1'b0;
        if (start_det) begin
            // Repeated start may cut in anywhere; let go of SDA and rebuild the frame
            d.st     = I2CRD_ADDR;
            d.cnt    = 3'h0;
            d.ack_on = 1'b0;
            d.sda_oe = 1'b0;
            d.busy   = 1'b1;
        end else if (stop_det) begin
            d.st     = I2CRD_IDLE;
            d.ack_on = 1'b0;
            d.sda_oe = 1'b0;
            d.busy   = 1'b0;
        end else begin
            unique case (q.st)
                I2CRD_IDLE: begin
                    // Bits clocked with no start before them are ignored
                    d.sda_oe = 1'b0;
                end
                I2CRD_ADDR: begin
                    if (scl_rise) begin
                        d.sh  = shift_in(q.sh, sda);
                        d.cnt = q.cnt + 3'h1;
                        if (last_bit(q.cnt)) begin
                            if (addr_hit) begin
                                d.st  = I2CRD_AACK;
                                d.nxt = sda ? I2CRD_TX : I2CRD_PTR;
                            end else begin
                                d.st = I2CRD_SKIP;
                            end
                        end
                    end
                end
                I2CRD_AACK: begin
                    // Drive and release only on SCL falls so SDA never moves while SCL is high
                    if (scl_fall) begin
                        if (!q.ack_on) begin
                            d.ack_on = 1'b1;
                            d.sda_oe = 1'b1;
                        end else begin
                            d.ack_on = 1'b0;
                            d.cnt    = 3'h0;
                            d.st     = q.nxt;
                            if (q.nxt == I2CRD_TX) begin
                                // Data is taken at the ack's closing fall, so the register must be valid by then
                                d.sh     = reg_rdata;
                                d.sda_oe = pull_for(reg_rdata[7]);
                                d.rd_stb = 1'b1;
                            end else begin
                                d.sda_oe = 1'b0;
                            end
                        end
                    end
                end
                I2CRD_PTR: begin
                    if (scl_rise) begin
                        d.sh  = shift_in(q.sh, sda);
                        d.cnt = q.cnt + 3'h1;
                        if (last_bit(q.cnt)) begin
                            d.ptr = shift_in(q.sh, sda);
                            d.st  = I2CRD_AACK;
                            // Write data is not taken, so the byte after the pointer goes unanswered
                            d.nxt = I2CRD_SKIP;
                        end
                    end
                end
                I2CRD_TX: begin
                    if (scl_fall) begin
                        if (last_bit(q.cnt)) begin
                            d.sda_oe = 1'b0;
                            d.st     = I2CRD_MACK;
                        end else begin
                            d.cnt    = q.cnt + 3'h1;
                            d.sh     = shift_in(q.sh, 1'b0);
                            d.sda_oe = pull_for(q.sh[6]);
                        end
                    end
                end
                I2CRD_MACK: begin
                    // Master's acknowledge bit; only a stop or repeated start follows
                    if (scl_rise) begin
                        d.st = I2CRD_SKIP;
                    end
                end
                I2CRD_SKIP: begin
                    d.sda_oe = 1'b0;
                end
                default: begin
                    // Only a corrupted one-hot code lands here
                    d.st     = I2CRD_IDLE;
                    d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    // The line is only ever pulled low, never driven high
    assign sda_o     = q.sda_o;
    assign sda_oe    = q.sda_oe;
    assign reg_ptr   = q.ptr;
    assign rd_strobe = q.rd_stb;
    assign busy      = q.busy;

endmodule // i2crd_slave

// >>> rtl/i2crd_sync.sv
`timescale 1ns/100ps
`include "i2crd_cfg.svh"

module i2crd_sync
    import i2crd_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rstn,
    input  wire logic [`I2CRD_SYN_W-1:0] din,
    output logic      [`I2CRD_SYN_W-1:0] dout
);

    i2crd_sync_t q;
    i2crd_sync_t d;

    // A bit moves only when the second and third stage agree, which drops single-cycle glitches
    always_comb begin
        d     = q;
        d.s1  = din;
        d.s2  = q.s1;
        d.s3  = q.s2;
        d.flt = (q.s2 & q.s3) | (q.flt & (q.s2 ^ q.s3));
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            q <= '{s1: `I2CRD_SYN_RST, s2: `I2CRD_SYN_RST, s3: `I2CRD_SYN_RST, flt: `I2CRD_SYN_RST};
        end else begin
            q <= d;
        end
    end

    assign dout = q.flt;

endmodule // i2crd_sync

// >>> verification/i2crd_checker.sv
`timescale 1ns/100ps

module i2crd_checker (
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic [7:0] reg_ptr,
    input wire logic       rd_strobe,
    input wire logic       busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_rst; $rose(rstn) |-> !sda_oe && !busy && !rd_strobe && reg_ptr == 8'h00; endproperty
    property p_od; sda_o == 1'b0; endproperty
    property p_oe_scl; $changed(sda_oe) |-> !scl_i; endproperty
    property p_oe_hold; $rose(sda_oe) |=> $stable(sda_oe) [*8]; endproperty
    property p_strobe; rd_strobe |=> !rd_strobe; endproperty
    property p_strobe_busy; rd_strobe |-> busy; endproperty
    property p_ptr; $changed(reg_ptr) |-> busy; endproperty
    property p_idle; !busy |-> !sda_oe; endproperty
    property p_start; scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:8] busy; endproperty
    property p_stop; scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:8] !busy; endproperty

    a_rst: assert property (p_rst) else $error("bad state after reset");
    a_od: assert property (p_od) else $error("sda driven high");
    a_oe_scl: assert property (p_oe_scl) else $error("sda moved with scl high");
    a_oe_hold: assert property (p_oe_hold) else $error("ack too short");
    a_strobe: assert property (p_strobe) else $error("strobe too long");
    a_strobe_busy: assert property (p_strobe_busy) else $error("strobe while idle");
    a_ptr: assert property (p_ptr) else $error("pointer moved while idle");
    a_idle: assert property (p_idle) else $error("sda driven while idle");
    a_start: assert property (p_start) else $error("start missed");
    a_stop: assert property (p_stop) else $error("stop missed");

    c_strobe: cover property (rd_strobe);
    c_ack: cover property ($rose(sda_oe));
    c_end: cover property ($fell(busy));
endmodule // i2crd_checker

bind i2crd_slave i2crd_checker u_chk (.sys_clk(sys_clk), .rstn(rstn), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .reg_ptr(reg_ptr), .rd_strobe(rd_strobe), .busy(busy));

// >>> verification/i2crd_master.sv
`timescale 1ns/100ps

module i2crd_master (
    input  wire logic sys_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_drv
);
    // Quarter of an SCL period in clock cycles; 5 gives the 160 ns link clock
    int q = 5;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic w(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // SDA goes high before SCL so a repeated start is never seen as a stop
    task automatic start();
        w(q);
        sda_drv = 1'b1;
        w(q);
        scl = 1'b1;
        w(q);
        sda_drv = 1'b0;
        w(q);
        scl = 1'b0;
    endtask

    task automatic stop();
        w(q);
        sda_drv = 1'b0;
        w(q);
        scl = 1'b1;
        w(q);
        sda_drv = 1'b1;
        w(q);
    endtask

    task automatic bit_x(input logic b, output logic r);
        w(q);
        sda_drv = b;
        w(q);
        scl = 1'b1;
        w(q);
        r = sda;
        w(q);
        scl = 1'b0;
    endtask

    // Eight bits MSB first, then the answer bit
    task automatic xfer(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) bit_x(d[i], r[i]);
    endtask
endmodule // i2crd_master

// >>> verification/tb_i2crd_slave.sv
`timescale 1ns/100ps

module tb_i2crd_slave;
    localparam logic [3:0] DEV = 4'h5; // Arbitrary value
    logic       sys_clk = 1'b0;
    logic       rstn = 1'b0;
    logic [2:0] addr_sel = 3'h3;
    logic [7:0] reg_rdata = 8'h00;
    logic       sda_o, sda_oe, rd_strobe, busy, scl, sda_drv;
    logic [7:0] reg_ptr;
    logic [8:0] r;
    int         n_mismatch = 0;
    int         samples_checked = 0;
    int         n_rd = 0;
    // Pull-up: the wire is high unless someone pulls it low
    wire        sda = sda_drv & ~sda_oe;

    always #4 sys_clk = ~sys_clk;
    always @(negedge sys_clk) reg_rdata <= ~{reg_ptr[3:0], reg_ptr[7:4]};
    // Counts read strobes so each read can be held to exactly one
    always @(negedge sys_clk) begin
        if (rd_strobe === 1'b1) n_rd++;
    end

    i2crd_slave #(.DEV_ID(DEV)) uut (.sys_clk(sys_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_sel(addr_sel), .reg_ptr(reg_ptr), .reg_rdata(reg_rdata),
        .rd_strobe(rd_strobe), .busy(busy));
    i2crd_master m (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic addr(input logic rw, input logic [2:0] sel, input logic ack);
        m.start();
        m.xfer({DEV, sel, rw, 1'b1}, r);
        chk("addr ack", {7'h0, ~ack}, {7'h0, r[0]});
    endtask

    task automatic set_ptr(input logic [7:0] p);
        addr(1'b0, addr_sel, 1'b1);
        m.xfer({p, 1'b1}, r);
        chk("ptr ack", 8'h00, {7'h0, r[0]});
        chk("reg_ptr", p, reg_ptr);
    endtask

    task automatic get(input logic [7:0] p);
        int c0;
        c0 = n_rd;
        addr(1'b1, addr_sel, 1'b1);
        m.xfer({8'hff, 1'b0}, r);
        chk("rdata", ~{p[3:0], p[7:4]}, r[8:1]);
        chk("read strobes", 8'(c0 + 1), 8'(n_rd));
        chk("busy", 8'h01, {7'h0, busy});
    endtask

    task automatic t_reset();
        chk("reg_ptr", 8'h00, reg_ptr);
        chk("flags", 8'h00, {5'h0, busy, sda_oe, rd_strobe});
        $display("test reset done");
    endtask

    task automatic t_read();
        set_ptr(8'h6d);
        get(8'h6d);
        m.stop();
        chk("busy", 8'h00, {7'h0, busy});
        $display("test read done");
    endtask

    // Pointer survives a stop, a reread and a foreign address
    task automatic t_reread();
        get(8'h6d);
        get(8'h6d);
        set_ptr(8'h01);
        m.xfer({8'h92, 1'b1}, r);
        chk("data nack", 8'h01, {7'h0, r[0]});
        get(8'h01);
        addr(1'b0, 3'h4, 1'b0);
        m.xfer({8'hee, 1'b1}, r);
        chk("ignored nack", 8'h01, {7'h0, r[0]});
        chk("ignored ptr", 8'h01, reg_ptr);
        m.stop();
        $display("test reread done");
    endtask

    task automatic t_sel();
        for (int s = 0; s < 8; s += 7) begin
            addr_sel = 3'(s);
            set_ptr(8'(8'h80 + s));
            get(8'(8'h80 + s));
            m.stop();
        end
        $display("test select done");
    endtask

    // 4 x 78 cycles of 8 ns is close to 400 kHz and 4 x 312 gives 100 kHz
    task automatic t_slow();
        for (int k = 0; k < 2; k++) begin
            m.q = (k == 0) ? 78 : 312;
            get(8'h87);
            m.stop();
        end
        m.q = 5;
        $display("test slow done");
    endtask

    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge sys_clk);
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (8) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (10) @(negedge sys_clk);
        t_reset();
        t_read();
        t_reread();
        t_sel();
        t_slow();
        final_report();
    end
endmodule // tb_i2crd_slave
